// File: shared/crf_pkg.sv
package crf_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int GPR_COUNT = 8;
  localparam int GPR_W = 32;
  localparam int IP_W = 24;
  localparam int FLAG_W = 8;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [23:0] IP_STEP = 24'h000002;

  // ---------------------------------------------------------------
  // operand sizes and halves
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // part bit: word 1 = upper half, 0 = lower; byte 1 = high, 0 = low
  localparam logic PART_UPPER = 1'b1;

  // ---------------------------------------------------------------
  // condition flag bit positions and reset value
  // ---------------------------------------------------------------
  localparam int FL_MASK = 7;
  localparam int FL_USER6 = 6;
  localparam int FL_HALF = 5;
  localparam int FL_USER4 = 4;
  localparam int FL_NEG = 3;
  localparam int FL_ZERO = 2;
  localparam int FL_OVF = 1;
  localparam int FL_CARRY = 0;
  localparam logic FL_MASK_RESET = 1'b1;

  // half carry taken out of these bits per size
  localparam int HC_BIT_BYTE = 3;
  localparam int HC_BIT_WORD = 11;
  localparam int HC_BIT_LONG = 27;

  // ---------------------------------------------------------------
  // flag register transfer and logic operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CRF_FOP_NONE = 3'b000,
    CRF_FOP_LOAD = 3'b001,
    CRF_FOP_AND = 3'b010,
    CRF_FOP_OR = 3'b011,
    CRF_FOP_XOR = 3'b100
  } crf_fop_t;

  // ---------------------------------------------------------------
  // reset sequence states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    CRF_ST_VEC = 1'b0,
    CRF_ST_RUN = 1'b1
  } crf_state_t;
endpackage

// File: shared/crf_alu_if.sv
`timescale 1ns/1ps
// operands to the flag unit and its flag results
interface crf_alu_if;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic sub;
  logic carry_in;
  logic [1:0] size;
  logic [31:0] result;
  logic half;
  logic neg;
  logic zero;
  logic ovf;
  logic carry;

  modport core (
    output op_a, op_b, sub, carry_in, size,
    input result, half, neg, zero, ovf, carry
  );
  modport unit (
    input op_a, op_b, sub, carry_in, size,
    output result, half, neg, zero, ovf, carry
  );
endinterface // crf_alu_if

// File: hdl/crf_flag_unit.sv
`timescale 1ns/1ps
module crf_flag_unit
  import crf_pkg::*;
(
  crf_alu_if.unit alu
);
  logic [31:0] size_mask;
  logic [31:0] a_m;
  logic [31:0] b_x;
  logic [32:0] sum;
  logic [32:0] carry_into;
  int msb;
  int hcb;

  // ------------------------
  // masked add of a and b (b inverted for subtract)
  // ------------------------
  always_comb begin
    case (alu.size)
      SZ_BYTE: begin
        size_mask = 32'h000000FF;
        msb = 7;
        hcb = HC_BIT_BYTE;
      end
      SZ_WORD: begin
        size_mask = 32'h0000FFFF;
        msb = 15;
        hcb = HC_BIT_WORD;
      end
      default: begin
        size_mask = 32'hFFFFFFFF;
        msb = 31;
        hcb = HC_BIT_LONG;
      end
    endcase
    a_m = alu.op_a & size_mask;
    b_x = (alu.sub ? ~alu.op_b : alu.op_b) & size_mask;
    // subtract: a + ~b + 1 - borrow_in
    sum = {1'b0, a_m} + {1'b0, b_x}
        + {32'h00000000, alu.sub ^ alu.carry_in};
    carry_into = sum ^ {1'b0, a_m} ^ {1'b0, b_x};
  end

  // ------------------------
  // flags from the sum; borrow is inverted carry
  // ------------------------
  always_comb begin
    alu.result = sum[31:0] & size_mask;
    // (RULE13) (RULE14) (RULE15) half carry per size
    alu.half = carry_into[hcb + 1] ^ alu.sub;
    // (RULE19) sign and zero
    alu.neg = sum[msb];
    alu.zero = ((sum[31:0] & size_mask) == 32'h00000000);
    // (RULE20) signed overflow
    alu.ovf = carry_into[msb] ^ carry_into[msb + 1];
    // (RULE21) carry or borrow
    alu.carry = carry_into[msb + 1] ^ alu.sub;
  end
endmodule // crf_flag_unit

// File: hdl/crf_regfile.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) eight identical 32-bit general registers
// (RULE2) data access at 32, 16, 8 bits
// (RULE3) each splits into two 16-bit halves
// (RULE4) lower half splits into two bytes
// (RULE5) access width chosen per register access
// (RULE6) register seven is also stack pointer
// (RULE7) 24-bit next instruction pointer
// (RULE8) fetch address forces bit zero low
// (RULE9) reset sequence loads pointer from vector
// (RULE10) reset sets mask bit, others untouched
// (RULE11) mask blocks all but nonmaskable interrupt
// (RULE12) exception start sets mask bit
// (RULE13) byte ops: half carry at bit 3
// (RULE14) word ops: half carry at bit 11
// (RULE15) long ops: half carry at bit 27
// (RULE16) user bits six, four: no effect
// (RULE17) flags written by transfer, logic ops
// (RULE18) branch uses only N, Z, V, C
// (RULE19) N is sign, Z is zero result
// (RULE20) V set on arithmetic overflow
// (RULE21) C: carry, borrow, shift-out, bit accumulator
// (RULE22) narrow writes keep other register bits
module crf_regfile
  import crf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // read port a
  input wire logic [2:0] rd_a_sel,
  input wire logic [1:0] rd_a_size,
  input wire logic rd_a_part,
  output logic [31:0] rd_a_data,
  // read port b
  input wire logic [2:0] rd_b_sel,
  input wire logic [1:0] rd_b_size,
  input wire logic rd_b_part,
  output logic [31:0] rd_b_data,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [1:0] wr_size,
  input wire logic wr_part,
  input wire logic [31:0] wr_data,
  // implicit stack pointer adjust
  input wire logic sp_inc_en,
  input wire logic sp_dec_en,
  input wire logic [2:0] sp_step,
  output logic [31:0] stack_pointer,
  // instruction pointer
  input wire logic ip_load_en,
  input wire logic [23:0] ip_load_val,
  input wire logic ip_inc_en,
  output logic [23:0] instruction_pointer,
  output logic [23:0] fetch_addr,
  // reset vector fetch
  output logic vec_req,
  input wire logic vec_valid,
  input wire logic [23:0] vec_addr,
  output logic core_ready,
  // exceptions and interrupts
  input wire logic exc_start,
  input wire logic irq_req,
  input wire logic nmi_req,
  output logic irq_accept,
  output logic nmi_accept,
  // flag register transfer and logic
  input wire logic [2:0] flag_op,
  input wire logic [7:0] flag_src,
  output logic [7:0] condition_flags,
  // arithmetic flag update
  input wire logic alu_en,
  input wire logic alu_sub,
  input wire logic alu_ext,
  input wire logic [1:0] alu_size,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  output logic [31:0] alu_result,
  // carry load for shifts and bit ops
  input wire logic c_load_en,
  input wire logic c_load_val,
  // branch condition
  input wire logic [3:0] cond_code,
  output logic branch_taken
);
  logic [31:0] gpr [GPR_COUNT];
  logic [23:0] ip;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [31:0] next_sp;
  logic sp_adjust;
  crf_state_t state;
  crf_alu_if alu ();

  // -------------------------------------------------------------
  // read extract: zero-extended sub-register
  // -------------------------------------------------------------
  function automatic logic [31:0] rd_extract(
    input logic [31:0] word,
    input logic [1:0] size,
    input logic part
  );
    logic [31:0] val;
    val = word;
    case (size)
      SZ_BYTE: val = {24'h000000,
        (part == PART_UPPER) ? word[15:8] : word[7:0]};
      SZ_WORD: val = {16'h0000,
        (part == PART_UPPER) ? word[31:16] : word[15:0]};
      default: val = word;
    endcase
    return val;
  endfunction

  // -------------------------------------------------------------
  // write merge: only the addressed bits change
  // -------------------------------------------------------------
  function automatic logic [31:0] wr_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [1:0] size,
    input logic part
  );
    logic [31:0] val;
    val = old;
    case (size)
      SZ_BYTE: begin
        if (part == PART_UPPER) begin
          val[15:8] = data[7:0];
        end else begin
          val[7:0] = data[7:0];
        end
      end
      SZ_WORD: begin
        if (part == PART_UPPER) begin
          val[31:16] = data[15:0];
        end else begin
          val[15:0] = data[15:0];
        end
      end
      default: val = data;
    endcase
    return val;
  endfunction

  // -------------------------------------------------------------
  // general registers
  // -------------------------------------------------------------
  assign sp_adjust = (sp_inc_en | sp_dec_en)
                   & ~(wr_en & (wr_sel == SP_INDEX));
  // stack pointer moves by the step in either direction
  always_comb begin
    next_sp = gpr[SP_INDEX];
    if (sp_inc_en) begin
      next_sp = gpr[SP_INDEX] + {29'h00000000, sp_step};
    end else if (sp_dec_en) begin
      next_sp = gpr[SP_INDEX] - {29'h00000000, sp_step};
    end
  end

  // (RULE1) eight identical registers, one update slice each
  for (genvar g = 0; g < GPR_COUNT; g++) begin : g_gpr
    always_ff @(posedge core_clk) begin
      // (RULE22) merge keeps untouched bits
      if (wr_en && wr_sel == 3'(g)) begin
        gpr[g] <= wr_merge(gpr[g], wr_data, wr_size, wr_part);
      // (RULE6) implicit stack moves on the last register
      end else if (3'(g) == SP_INDEX && sp_adjust) begin
        gpr[g] <= next_sp;
      end
    end
  end

  // (RULE2) (RULE3) (RULE4) (RULE5) per-access width and part
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_a_data <= 32'h00000000;
      rd_b_data <= 32'h00000000;
    end else begin
      rd_a_data <= rd_extract(gpr[rd_a_sel], rd_a_size, rd_a_part);
      rd_b_data <= rd_extract(gpr[rd_b_sel], rd_b_size, rd_b_part);
    end
  end

  // (RULE6) stack pointer copy mirrors register seven
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stack_pointer <= 32'h00000000;
    end else if (wr_en && wr_sel == SP_INDEX) begin
      stack_pointer <= wr_merge(gpr[SP_INDEX], wr_data, wr_size,
                                wr_part);
    end else if (sp_adjust) begin
      stack_pointer <= next_sp;
    end else begin
      stack_pointer <= gpr[SP_INDEX];
    end
  end

  // -------------------------------------------------------------
  // reset sequence and instruction pointer
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= CRF_ST_VEC;
    end else begin
      case (state)
        CRF_ST_VEC: begin
          if (vec_valid) begin
            state <= CRF_ST_RUN;
          end
        end
        CRF_ST_RUN: state <= CRF_ST_RUN;
        default: state <= CRF_ST_VEC;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      vec_req <= 1'b1;
      core_ready <= 1'b0;
    end else begin
      vec_req <= (state == CRF_ST_VEC) && !vec_valid;
      core_ready <= (state == CRF_ST_RUN) || vec_valid;
    end
  end

  // (RULE7) pointer to the next instruction
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ip <= 24'h000000;
    // (RULE9) start address from the reset vector
    end else if (state == CRF_ST_VEC) begin
      if (vec_valid) begin
        ip <= vec_addr;
      end
    end else if (ip_load_en) begin
      ip <= ip_load_val;
    end else if (ip_inc_en) begin
      ip <= ip + IP_STEP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      instruction_pointer <= 24'h000000;
      fetch_addr <= 24'h000000;
    end else begin
      instruction_pointer <= ip;
      // (RULE8) fetches are word aligned
      fetch_addr <= {ip[23:1], 1'b0};
    end
  end

  // -------------------------------------------------------------
  // interrupt gating
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_accept <= 1'b0;
      nmi_accept <= 1'b0;
    end else begin
      // (RULE11) mask blocks ordinary requests only
      irq_accept <= irq_req && !flags[FL_MASK] && !nmi_req
                 && (state == CRF_ST_RUN);
      nmi_accept <= nmi_req && (state == CRF_ST_RUN);
    end
  end

  // -------------------------------------------------------------
  // arithmetic flag unit
  // -------------------------------------------------------------
  assign alu.op_a = alu_a;
  assign alu.op_b = alu_b;
  assign alu.sub = alu_sub;
  assign alu.carry_in = alu_ext & flags[FL_CARRY];
  assign alu.size = alu_size;

  crf_flag_unit u_flag_unit (
    .alu (alu.unit)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      alu_result <= 32'h00000000;
    end else begin
      alu_result <= alu.result;
    end
  end

  // -------------------------------------------------------------
  // condition flags next value
  // -------------------------------------------------------------
  always_comb begin
    next_flags = flags;
    // (RULE17) transfer and logic ops on the flag register
    case (crf_fop_t'(flag_op))
      CRF_FOP_LOAD: next_flags = flag_src;
      CRF_FOP_AND: next_flags = flags & flag_src;
      CRF_FOP_OR: next_flags = flags | flag_src;
      CRF_FOP_XOR: next_flags = flags ^ flag_src;
      default: begin
        // (RULE16) user bits kept by arithmetic
        if (alu_en) begin
          // (RULE13) (RULE14) (RULE15) size picks the carry bit
          next_flags[FL_HALF] = alu.half;
          // (RULE19) sign and zero; extend ops keep zero sticky
          next_flags[FL_NEG] = alu.neg;
          next_flags[FL_ZERO] = alu_ext ? (flags[FL_ZERO] & alu.zero)
                                        : alu.zero;
          // (RULE20) overflow
          next_flags[FL_OVF] = alu.ovf;
          // (RULE21) carry or borrow
          next_flags[FL_CARRY] = alu.carry;
        end
        // (RULE21) shifted-out bit or bit accumulator
        if (c_load_en) begin
          next_flags[FL_CARRY] = c_load_val;
        end
      end
    endcase
    // (RULE12) exception start sets mask, winning over writes
    if (exc_start) begin
      next_flags[FL_MASK] = 1'b1;
    end
  end

  // (RULE10) only the mask bit takes a reset value
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flags[FL_MASK] <= FL_MASK_RESET;
    end else if (state == CRF_ST_VEC) begin
      flags[FL_MASK] <= FL_MASK_RESET;
    end else begin
      flags[FL_MASK] <= next_flags[FL_MASK];
    end
  end

  always_ff @(posedge core_clk) begin
    if (state == CRF_ST_RUN) begin
      flags[6:0] <= next_flags[6:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      condition_flags <= {FL_MASK_RESET, 7'h00};
    end else begin
      condition_flags <= flags;
    end
  end

  // -------------------------------------------------------------
  // branch condition
  // -------------------------------------------------------------
  // (RULE18) only N, Z, V and C are looked at
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      branch_taken <= 1'b0;
    end else begin
      case (cond_code)
        4'h0: branch_taken <= 1'b1;
        4'h1: branch_taken <= 1'b0;
        4'h2: branch_taken <= !(flags[FL_CARRY] | flags[FL_ZERO]);
        4'h3: branch_taken <= flags[FL_CARRY] | flags[FL_ZERO];
        4'h4: branch_taken <= !flags[FL_CARRY];
        4'h5: branch_taken <= flags[FL_CARRY];
        4'h6: branch_taken <= !flags[FL_ZERO];
        4'h7: branch_taken <= flags[FL_ZERO];
        4'h8: branch_taken <= !flags[FL_OVF];
        4'h9: branch_taken <= flags[FL_OVF];
        4'hA: branch_taken <= !flags[FL_NEG];
        4'hB: branch_taken <= flags[FL_NEG];
        4'hC: branch_taken <= flags[FL_NEG] == flags[FL_OVF];
        4'hD: branch_taken <= flags[FL_NEG] != flags[FL_OVF];
        4'hE: branch_taken <= !flags[FL_ZERO]
                           && (flags[FL_NEG] == flags[FL_OVF]);
        default: branch_taken <= flags[FL_ZERO]
                              || (flags[FL_NEG] != flags[FL_OVF]);
      endcase
    end
  end
endmodule // crf_regfile

// File: test/crf_regfile_monitor.sv
`timescale 1ns/1ps
module crf_regfile_monitor
  import crf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register and pointer side
  input wire logic [1:0] rd_a_size,
  input wire logic [31:0] rd_a_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic sp_inc_en,
  input wire logic [2:0] sp_step,
  input wire logic [31:0] stack_pointer,
  input wire logic [23:0] instruction_pointer,
  input wire logic [23:0] fetch_addr,
  input wire logic vec_req,
  input wire logic vec_valid,
  input wire logic [23:0] vec_addr,
  input wire logic core_ready,
  // flags side
  input wire logic exc_start,
  input wire logic nmi_req,
  input wire logic irq_accept,
  input wire logic nmi_accept,
  input wire logic [2:0] flag_op,
  input wire logic [7:0] condition_flags,
  input wire logic alu_en,
  input wire logic alu_sub,
  input wire logic alu_ext,
  input wire logic [1:0] alu_size,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic [3:0] cond_code,
  input wire logic branch_taken
);
  logic exp_half;

  // carry or borrow out of the half-carry bit for the operand size
  function automatic logic half_of(logic [31:0] a, logic [31:0] b,
                                   logic s, logic [1:0] z);
    int n;
    logic [32:0] m;
    n = (z == SZ_BYTE) ? HC_BIT_BYTE + 1 :
        (z == SZ_WORD) ? HC_BIT_WORD + 1 : HC_BIT_LONG + 1;
    m = (33'h1 << n) - 33'h1;
    if (s)
      return ({1'b0, a} & m) < ({1'b0, b} & m);
    return ((({1'b0, a} & m) + ({1'b0, b} & m)) >> n) != 33'h0;
  endfunction

  assign exp_half = half_of(alu_a, alu_b, alu_sub, alu_size);

  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // vector taken, then ready, then pointer loaded
  sequence vec_taken_s;
    ##1 (core_ready && !vec_req)
    ##1 (instruction_pointer == $past(vec_addr, 2));
  endsequence

  reset_mask_set_a: assert property (
    $rose(rst_b) |-> condition_flags[FL_MASK] && vec_req && !core_ready
  ) else $error("mask bit clear after reset");
  vector_load_a: assert property (
    vec_req && vec_valid |-> vec_taken_s
  ) else $error("start address not loaded");
  fetch_align_a: assert property (
    fetch_addr == {instruction_pointer[23:1], 1'b0}
  ) else $error("fetch address unaligned");
  sp_adjust_a: assert property (
    sp_inc_en && !(wr_en && wr_sel == SP_INDEX) |=>
      stack_pointer == $past(stack_pointer) + 32'(sp_step)
  ) else $error("stack pointer step wrong");
  byte_read_a: assert property (
    rd_a_size == SZ_BYTE |=> rd_a_data[31:8] == 24'h0
  ) else $error("byte read not extended");
  word_read_a: assert property (
    rd_a_size == SZ_WORD |=> rd_a_data[31:16] == 16'h0
  ) else $error("word read not extended");
  exc_mask_a: assert property (
    exc_start |-> ##2 condition_flags[FL_MASK]
  ) else $error("exception did not set mask");
  mask_blocks_a: assert property (
    condition_flags[FL_MASK] |-> !irq_accept
  ) else $error("interrupt accepted while masked");
  nmi_pass_a: assert property (
    nmi_req && core_ready |=> nmi_accept
  ) else $error("nmi not accepted");
  half_carry_a: assert property (
    alu_en && core_ready && flag_op == 3'h0 && !alu_ext |->
      ##2 condition_flags[FL_HALF] == $past(exp_half, 2)
  ) else $error("half carry flag wrong");
  eq_branch_a: assert property (
    cond_code == 4'h7 |=> branch_taken == condition_flags[FL_ZERO]
  ) else $error("equal branch wrong");
endmodule // crf_regfile_monitor

bind crf_regfile crf_regfile_monitor mon_u (.*);

// File: test/crf_vec_model.sv
`timescale 1ns/1ps
module crf_vec_model
#(
  parameter logic [23:0] START = 24'h000100,
  parameter int DELAY = 2
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // vector handshake
  input wire logic vec_req,
  output logic vec_valid,
  output logic [23:0] vec_addr
);
  int wait_cnt;

  // answer the vector request after a few cycles
  always_ff @(posedge core_clk) begin
    if (!rst_b || !vec_req) begin
      wait_cnt <= 0;
      vec_valid <= 1'b0;
    end else if (wait_cnt == DELAY) begin
      vec_valid <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // address lines carry junk while not valid
  assign vec_addr = vec_valid ? START : ~START;
endmodule // crf_vec_model

// File: test/cpu_register_file_flags_test.sv
`timescale 1ns/1ps
module cpu_register_file_flags_test
  import crf_pkg::*;
;
  localparam logic [23:0] VEC_START = 24'h000103;
  logic core_clk = 1'b0, rst_b = 1'b0, rd_a_part = 1'b0, wr_en = 1'b0;
  logic wr_part = 1'b0, sp_inc_en = 1'b0, sp_dec_en = 1'b0;
  logic ip_load_en = 1'b0, ip_inc_en = 1'b0, exc_start = 1'b0;
  logic irq_req = 1'b0, nmi_req = 1'b0, alu_en = 1'b0, alu_sub = 1'b0;
  logic c_load_en = 1'b0, c_load_val = 1'b0;
  logic [2:0] rd_a_sel = 3'h0, wr_sel = 3'h0, sp_step = 3'h0;
  logic [2:0] flag_op = 3'h0;
  logic [1:0] rd_a_size = 2'h0, wr_size = 2'h0, alu_size = 2'h0;
  logic [31:0] wr_data = 32'h0, alu_a = 32'h0, alu_b = 32'h0;
  logic [23:0] ip_load_val = 24'h0;
  logic [7:0] flag_src = 8'h0;
  logic [3:0] cond_code = 4'h0;
  logic vec_req, vec_valid, core_ready, irq_accept, nmi_accept;
  logic branch_taken;
  logic [31:0] rd_a_data, stack_pointer;
  logic [23:0] instruction_pointer, fetch_addr, vec_addr;
  logic [7:0] condition_flags;
  int fail_count = 0;
  int compares = 0;

  // --------------------
  // design, vector source and clock
  // --------------------
  crf_regfile dut_u (
    .core_clk, .rst_b, .rd_a_sel, .rd_a_size, .rd_a_part, .rd_a_data,
    .rd_b_sel(3'h0), .rd_b_size(SZ_LONG), .rd_b_part(1'b0), .rd_b_data(),
    .wr_en, .wr_sel, .wr_size, .wr_part, .wr_data, .sp_inc_en,
    .sp_dec_en, .sp_step, .stack_pointer, .ip_load_en, .ip_load_val,
    .ip_inc_en, .instruction_pointer, .fetch_addr, .vec_req, .vec_valid,
    .vec_addr, .core_ready, .exc_start, .irq_req, .nmi_req, .irq_accept,
    .nmi_accept, .flag_op, .flag_src, .condition_flags, .alu_en,
    .alu_sub, .alu_ext(1'b0), .alu_size, .alu_a, .alu_b, .alu_result(),
    .c_load_en, .c_load_val, .cond_code, .branch_taken
  );
  crf_vec_model #(.START(VEC_START), .DELAY(3)) vec_u (
    .core_clk, .rst_b, .vec_req, .vec_valid, .vec_addr
  );
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // --------------------
  // access tasks
  // --------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // start of an operation; ends any write run
  task automatic go();
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // drop all strobes, let flags reach the mirror
  task automatic settle();
    @(posedge core_clk);
    {wr_en, sp_inc_en, sp_dec_en, ip_load_en, ip_inc_en, exc_start} <= 6'h0;
    {alu_en, c_load_en, flag_op} <= 5'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [2:0] s, logic [1:0] z, logic p, logic [31:0] d);
    @(posedge core_clk);
    {wr_en, wr_sel, wr_size, wr_part, wr_data} <= {1'b1, s, z, p, d};
  endtask
  task automatic rd(logic [2:0] s, logic [1:0] z, logic p, logic [31:0] e);
    go();
    {rd_a_sel, rd_a_size, rd_a_part} <= {s, z, p};
    @(posedge core_clk);
    #1;
    check("rd_a_data", rd_a_data, e);
  endtask
  task automatic fop(crf_fop_t op, logic [7:0] src, logic [7:0] e);
    go();
    {flag_op, flag_src} <= {op, src};
    settle();
    check("condition_flags", 32'(condition_flags), 32'(e));
  endtask
  task automatic alu_op(logic s, logic [1:0] z, logic [31:0] a,
                        logic [31:0] b, logic [7:0] e);
    go();
    {alu_en, alu_sub, alu_size, alu_a, alu_b} <= {1'b1, s, z, a, b};
    settle();
    check("arith flags", 32'(condition_flags & 8'h2F), 32'(e));
  endtask
  task automatic br(logic [3:0] c, logic e);
    go();
    cond_code <= c;
    @(posedge core_clk);
    #1;
    check("branch_taken", 32'(branch_taken), 32'(e));
  endtask

  // --------------------
  // test sequence
  // --------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 20 && core_ready !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    check("instruction_pointer", 32'(instruction_pointer), 32'(VEC_START));
    check("fetch_addr", 32'(fetch_addr), 32'h00000102);
    check("mask bit", 32'(condition_flags[FL_MASK]), 32'h1);
    $display("test reset vector done");
    for (int i = 0; i < GPR_COUNT; i++)
      wr(3'(i), SZ_LONG, 1'b0, 32'h90000000 + 32'h01010101 * 32'(i));
    for (int i = 0; i < GPR_COUNT; i++)
      rd(3'(i), SZ_LONG, 1'b0, 32'h90000000 + 32'h01010101 * 32'(i));
    wr(3'h3, SZ_BYTE, 1'b1, 32'h000000C3);
    wr(3'h3, SZ_WORD, 1'b1, 32'h0000BEEF);
    wr(3'h3, SZ_BYTE, 1'b0, 32'h00000011);
    wr(3'h4, SZ_WORD, 1'b0, 32'h00002222);
    rd(3'h3, SZ_LONG, 1'b0, 32'hBEEFC311);
    rd(3'h3, SZ_WORD, 1'b1, 32'h0000BEEF);
    rd(3'h3, SZ_WORD, 1'b0, 32'h0000C311);
    rd(3'h3, SZ_BYTE, 1'b1, 32'h000000C3);
    rd(3'h3, SZ_BYTE, 1'b0, 32'h00000011);
    rd(3'h4, SZ_LONG, 1'b0, 32'h94042222);
    $display("test sub registers done");
    wr(SP_INDEX, SZ_LONG, 1'b0, 32'h00001000);
    go();
    {sp_dec_en, sp_step} <= {1'b1, 3'h4};
    settle();
    check("stack_pointer", stack_pointer, 32'h00000FFC);
    go();
    {sp_inc_en, sp_dec_en, sp_step} <= {2'h3, 3'h2};
    settle();
    check("stack_pointer", stack_pointer, 32'h00000FFE);
    wr(SP_INDEX, SZ_LONG, 1'b0, 32'h00002000);
    sp_dec_en <= 1'b1;
    settle();
    rd(SP_INDEX, SZ_LONG, 1'b0, 32'h00002000);
    go();
    {ip_load_en, ip_load_val} <= {1'b1, 24'h00ABCD};
    settle();
    check("instruction_pointer", 32'(instruction_pointer), 32'h00ABCD);
    go();
    ip_inc_en <= 1'b1;
    settle();
    check("instruction_pointer", 32'(instruction_pointer), 32'h00ABCF);
    check("fetch_addr", 32'(fetch_addr), 32'h0000ABCE);
    $display("test pointers done");
    fop(CRF_FOP_LOAD, 8'h50, 8'h50);
    fop(CRF_FOP_AND, 8'h40, 8'h40);
    fop(CRF_FOP_OR, 8'h11, 8'h51);
    fop(CRF_FOP_XOR, 8'hFF, 8'hAE);
    fop(CRF_FOP_LOAD, 8'h50, 8'h50);
    go();
    irq_req <= 1'b1;
    @(posedge core_clk);
    #1;
    check("irq_accept", 32'(irq_accept), 32'h1);
    go();
    {flag_op, flag_src, exc_start} <= {CRF_FOP_AND, 8'h7F, 1'b1};
    settle();
    check("condition_flags", 32'(condition_flags), 32'h000000D0);
    check("irq_accept", 32'(irq_accept), 32'h0);
    go();
    nmi_req <= 1'b1;
    @(posedge core_clk);
    #1;
    check("nmi_accept", 32'(nmi_accept), 32'h1);
    {irq_req, nmi_req} <= 2'h0;
    $display("test flag register done");
    fop(CRF_FOP_LOAD, 8'h50, 8'h50);
    alu_op(1'b0, SZ_BYTE, 32'h0F, 32'h01, 8'h20);
    alu_op(1'b1, SZ_BYTE, 32'h10, 32'h01, 8'h20);
    alu_op(1'b0, SZ_BYTE, 32'h80, 32'h80, 8'h07);
    alu_op(1'b1, SZ_BYTE, 32'h00, 32'h01, 8'h29);
    alu_op(1'b0, SZ_WORD, 32'h0FFF, 32'h01, 8'h20);
    alu_op(1'b1, SZ_WORD, 32'h1000, 32'h01, 8'h20);
    alu_op(1'b0, SZ_LONG, 32'h7FFFFFFF, 32'h01, 8'h2A);
    alu_op(1'b1, SZ_LONG, 32'h05, 32'h05, 8'h04);
    check("user bits", 32'(condition_flags & 8'hD0), 32'h50);
    go();
    {c_load_en, c_load_val} <= 2'h3;
    settle();
    check("carry flag", 32'(condition_flags[FL_CARRY]), 32'h1);
    br(4'h7, 1'b1);
    br(4'h6, 1'b0);
    br(4'h5, 1'b1);
    br(4'h0, 1'b1);
    fop(CRF_FOP_LOAD, 8'h70, 8'h70);
    br(4'h7, 1'b0);
    br(4'hB, 1'b0);
    br(4'h9, 1'b0);
    $display("test arithmetic flags done");
    wrap_up();
  end

  // watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    $display("Error watchdog expired");
    wrap_up();
  end
endmodule // cpu_register_file_flags_test
